// *** tbp_pkg.sv ***
/*
 Constants for the timebase and module configuration block: register
 offsets, field positions, reset values and divider counts.
 Assumes a 32-bit APB slave with one register per aligned word.
*/
package tbp_pkg;
   localparam logic [11:0] ADDR_MODCFG = 12'h000;
   localparam logic [11:0] ADDR_INTCFG = 12'h008;
   localparam logic [11:0] ADDR_TB1 = 12'h010;
   localparam logic [11:0] ADDR_TB2 = 12'h014;
   localparam logic [11:0] ADDR_VECQ = 12'h018;
   // module_configuration fields
   localparam int STOP_BIT = 15;
   localparam int P1_LSB = 13;
   localparam int P2_LSB = 11;
   localparam int EMU_BIT = 10;
   localparam int CG_BIT = 9;
   localparam int STF_BIT = 8;
   localparam int SUPERVISOR_SPACE_BIT = 7;
   localparam int PRESCALER_CLOCK_SELECT_BIT = 6;
   localparam int ARB_LSB = 0;
   localparam logic [15:0] MODCFG_RESET = 16'h0080;
   // interrupt_configuration fields
   localparam int LVL_LSB = 8;
   localparam int BV_LSB = 4;
   localparam logic [15:0] INTCFG_RESET = 16'h0000;
   // Divider counts in system clocks
   localparam logic [4:0] DIV_SLOW = 5'h1F;
   localparam logic [4:0] DIV_FAST = 5'h03;
   localparam logic [2:0] DIV_EIGHT = 3'h7;
   localparam logic [1:0] FILT_LEN = 2'h3;
endpackage

// *** tbp_scaler.sv ***
/*
 Binary prescaler: passes one of every 1, 2, 4 or 8 input ticks.
 Assumes tick inputs are single-cycle pulses on clk.
*/
`timescale 1ns/1ps
module tbp_scaler (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic tickIn,
   input wire logic [1:0] sel,
   output logic tickOut
);
   logic [2:0] cnt;
   logic [2:0] mask;
   always_comb begin
      mask = 3'((4'h1 << sel) - 4'h1);
   end
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cnt <= 3'h0;
      end else if (tickIn) begin
         cnt <= ((cnt & mask) == mask) ? 3'h0 : cnt + 3'h1;
      end
   end
   assign tickOut = tickIn && ((cnt & mask) == mask);
endmodule

// *** tbp_timebase.sv ***
/*
 Module configuration, two timebase prescaler paths and counters,
 emulation and supervisor controls, interrupt configuration.
 Assumes an APB master on clk; the timebase pin is asynchronous.
// Summary of operation
// RULE_01: Stop bit shuts internal clocks down
// RULE_02: Stopped flag reads one once stopped
// RULE_03: First input is clock/32 or clock/4
// RULE_04: First field divides by 1,2,4,8
// RULE_05: Pin clocks second timebase, synced, filtered
// RULE_06: Gate mode: pin gates clock/8 tick
// RULE_07: Second field divides by 1,2,4,8
// RULE_08: Emulation routes fetch, blocks host RAM
// RULE_09: Emulation bit writable once per reset
// RULE_10: Supervisor bit decodes function line
// RULE_11: Software sets nonzero unique arbitration number
// RULE_12: Level seven nonmaskable, zero disables
// RULE_13: Vector is base nibble plus channel
// RULE_14: Timebases count up, hold while stopped
*/
// Implementation choices: the APB slave port and the register addresses.
`timescale 1ns/1ps
module tbp_timebase
   import tbp_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic timebasePin,
   input wire logic supervisorFunctionLine,
   input wire logic [3:0] reqChannel,
   output logic [15:0] firstTimebase,
   output logic [15:0] secondTimebase,
   output logic emulationFetchPath,
   output logic hostRamBlock,
   output logic registersRestricted,
   output logic [2:0] requestLevel,
   output logic nonmaskableReq,
   output logic channelIrqEnable,
   output logic [3:0] arbitrationNumber,
   output logic [7:0] interruptVector,
   output logic stopped
);
   import tbp_pkg::*;

   function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
      hit = (a == r);
   endfunction

   logic stopReq, emulation_select, emuWritten, cgSel, supervisor_space, prescaler_clock_select;
   logic [1:0] p1Sel, p2Sel;
   logic [3:0] arb;
   logic [2:0] lvl;
   logic [3:0] bv;
   logic wrEn, mapped;
   logic [15:0] modcfgView;

   assign wrEn = psel && penable && pwrite && pready;
   // Address decode used only by the error flag; read data decodes its own
   assign mapped = hit(paddr, ADDR_MODCFG) || hit(paddr, ADDR_INTCFG) ||
      hit(paddr, ADDR_TB1) || hit(paddr, ADDR_TB2) ||
      hit(paddr, ADDR_VECQ);
   assign modcfgView = {stopReq, p1Sel, p2Sel, emulation_select, cgSel, stopped, supervisor_space, prescaler_clock_select,
                        2'b00, arb};

   // Register writes
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         stopReq <= MODCFG_RESET[STOP_BIT];
         p1Sel <= MODCFG_RESET[P1_LSB +: 2];
         p2Sel <= MODCFG_RESET[P2_LSB +: 2];
         cgSel <= MODCFG_RESET[CG_BIT];
         supervisor_space <= MODCFG_RESET[SUPERVISOR_SPACE_BIT];
         prescaler_clock_select <= MODCFG_RESET[PRESCALER_CLOCK_SELECT_BIT];
         arb <= MODCFG_RESET[ARB_LSB +: 4];
         lvl <= INTCFG_RESET[LVL_LSB +: 3];
         bv <= INTCFG_RESET[BV_LSB +: 4];
      end else if (wrEn && hit(paddr, ADDR_MODCFG)) begin
         stopReq <= pwdata[STOP_BIT]; // [RULE_01]
         p1Sel <= pwdata[P1_LSB +: 2];
         p2Sel <= pwdata[P2_LSB +: 2];
         cgSel <= pwdata[CG_BIT];
         supervisor_space <= pwdata[SUPERVISOR_SPACE_BIT];
         prescaler_clock_select <= pwdata[PRESCALER_CLOCK_SELECT_BIT];
         arb <= pwdata[ARB_LSB +: 4];
      end else if (wrEn && hit(paddr, ADDR_INTCFG)) begin
         lvl <= pwdata[LVL_LSB +: 3];
         bv <= pwdata[BV_LSB +: 4];
      end
   end

   // Emulation bit takes only the first write after reset
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         emulation_select <= MODCFG_RESET[EMU_BIT];
         emuWritten <= 1'b0;
      end else if (wrEn && hit(paddr, ADDR_MODCFG) && !emuWritten) begin
         emulation_select <= pwdata[EMU_BIT]; // [RULE_09]
         emuWritten <= 1'b1;
      end
   end

   // APB answers in the access cycle; unmapped addresses flag an error
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         if (hit(paddr, ADDR_MODCFG)) prdata <= {16'h0000, modcfgView};
         else if (hit(paddr, ADDR_INTCFG)) prdata <= {21'h0, lvl, bv, 4'h0};
         else if (hit(paddr, ADDR_TB1)) prdata <= {16'h0000, firstTimebase};
         else if (hit(paddr, ADDR_TB2)) prdata <= {16'h0000, secondTimebase};
         else if (hit(paddr, ADDR_VECQ)) prdata <= {24'h0, interruptVector};
         else prdata <= 32'h0000_0000;
      end
   end
   // Ready from the first edge after reset; the error flag stands through the access phase
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= 1'b1;
         pslverr <= psel && !penable && !mapped;
      end
   end

   // Stopped flag follows the stop bit at the next edge
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) stopped <= 1'b0;
      else stopped <= stopReq; // [RULE_02]
   end

   // Base clock dividers, frozen while stopped
   logic [4:0] div1Cnt;
   logic [2:0] div8Cnt;
   logic base1Tick, div8Tick;
   logic [4:0] div1Limit;
   assign div1Limit = prescaler_clock_select ? DIV_FAST : DIV_SLOW; // [RULE_03]
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) div1Cnt <= 5'h00;
      else if (!stopped) div1Cnt <= (div1Cnt >= div1Limit) ? 5'h00 : div1Cnt + 5'h01;
   end
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) div8Cnt <= 3'h0;
      else if (!stopped) div8Cnt <= div8Cnt + 3'h1;
   end
   assign base1Tick = !stopped && (div1Cnt >= div1Limit); // [RULE_01]
   assign div8Tick = !stopped && (div8Cnt == DIV_EIGHT);

   // Pin synchroniser and digital filter
   logic pinMeta, pinSync, pinFilt, pinFiltDly;
   logic [1:0] filtCnt;
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pinMeta <= 1'b0;
         pinSync <= 1'b0;
      end else begin
         pinMeta <= timebasePin; // [RULE_05]
         pinSync <= pinMeta;
      end
   end
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         filtCnt <= 2'h0;
         pinFilt <= 1'b0;
         pinFiltDly <= 1'b0;
      end else begin
         pinFiltDly <= pinFilt;
         if (pinSync == pinFilt) filtCnt <= 2'h0;
         else if (filtCnt == FILT_LEN) begin
            pinFilt <= pinSync; // [RULE_05]
            filtCnt <= 2'h0;
         end else filtCnt <= filtCnt + 2'h1;
      end
   end

   logic base2Tick, tb1Tick, tb2Tick;
   always_comb begin
      if (cgSel) base2Tick = div8Tick && pinFilt; // [RULE_06]
      else base2Tick = !stopped && pinFilt && !pinFiltDly; // [RULE_05]
   end

   tbp_scaler uScale1 (
      .clk(clk),
      .sys_rst(sys_rst),
      .tickIn(base1Tick),
      .sel(p1Sel), // [RULE_04]
      .tickOut(tb1Tick)
   );
   tbp_scaler uScale2 (
      .clk(clk),
      .sys_rst(sys_rst),
      .tickIn(base2Tick),
      .sel(p2Sel), // [RULE_07]
      .tickOut(tb2Tick)
   );

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) firstTimebase <= 16'h0000;
      else if (tb1Tick) firstTimebase <= firstTimebase + 16'h0001; // [RULE_14]
   end
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) secondTimebase <= 16'h0000;
      else if (tb2Tick) secondTimebase <= secondTimebase + 16'h0001; // [RULE_14]
   end

   // Registered configuration outputs
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         emulationFetchPath <= 1'b0;
         hostRamBlock <= 1'b0;
         registersRestricted <= 1'b0;
         requestLevel <= 3'h0;
         nonmaskableReq <= 1'b0;
         channelIrqEnable <= 1'b0;
         arbitrationNumber <= 4'h0;
         interruptVector <= 8'h00;
      end else begin
         emulationFetchPath <= emulation_select; // [RULE_08]
         hostRamBlock <= emulation_select; // [RULE_08]
         registersRestricted <= supervisor_space && supervisorFunctionLine; // [RULE_10]
         requestLevel <= lvl;
         nonmaskableReq <= (lvl == 3'h7); // [RULE_12]
         channelIrqEnable <= (lvl != 3'h0); // [RULE_12]
         arbitrationNumber <= arb; // [RULE_11]
         interruptVector <= {bv, reqChannel}; // [RULE_13]
      end
   end

   // Register and emulation checks
   chk_emu_once: assert property (@(posedge clk) disable iff (sys_rst) // [RULE_09]
      $past(emuWritten) |-> emulation_select == $past(emulation_select))
      else $error("emulation bit changed twice");
   chk_emu_first: assert property (@(posedge clk) disable iff (sys_rst) // [RULE_09]
      wrEn && hit(paddr, ADDR_MODCFG) && !emuWritten |=> emulation_select == $past(pwdata[EMU_BIT]))
      else $error("first emulation write lost");
   chk_emu_block: assert property (@(posedge clk) disable iff (sys_rst) // [RULE_08]
      emulation_select |=> hostRamBlock && emulationFetchPath)
      else $error("emulation path wrong");
   chk_stop_flag: assert property (@(posedge clk) disable iff (sys_rst) // [RULE_02]
      $rose(stopReq) |=> stopped)
      else $error("stopped flag late");
   chk_stop_clear: assert property (@(posedge clk) disable iff (sys_rst) // [RULE_02]
      !stopReq |=> !stopped)
      else $error("stopped flag stuck");
   chk_supervisor_space_ignore: assert property (@(posedge clk) disable iff (sys_rst) // [RULE_10]
      !supervisor_space |=> !registersRestricted)
      else $error("function line not ignored");

   // Divider and filter checks
   chk_fast_div: assert property (@(posedge clk) disable iff (sys_rst) // [RULE_03]
      base1Tick && prescaler_clock_select ##1 (prescaler_clock_select && !stopped) [*4] |-> base1Tick)
      else $error("fast divider wrong");
   chk_div1_wrap: assert property (@(posedge clk) disable iff (sys_rst) // [RULE_03]
      base1Tick |=> div1Cnt == 5'h00)
      else $error("first divider did not wrap");
   chk_sysclk_div_eight_tick_rate: assert property (@(posedge clk) disable iff (sys_rst) // [RULE_06]
      div8Tick ##1 !stopped [*8] |-> div8Tick)
      else $error("eighth-clock tick rate wrong");
   chk_filter_hold: assert property (@(posedge clk) disable iff (sys_rst) // [RULE_05]
      $changed(pinFilt) |-> $past(pinSync) == pinFilt && $past(pinSync, 4) == pinFilt)
      else $error("pin filter passed a short pulse");

   // Counter checks
   chk_hold_stopped: assert property (@(posedge clk) disable iff (sys_rst) // [RULE_14]
      stopped ##1 stopped |-> $stable(firstTimebase))
      else $error("first timebase moved while stopped");
   chk_hold_second: assert property (@(posedge clk) disable iff (sys_rst) // [RULE_14]
      stopped ##1 stopped |-> $stable(secondTimebase))
      else $error("second timebase moved while stopped");
   chk_tb1_step: assert property (@(posedge clk) disable iff (sys_rst) // [RULE_14]
      tb1Tick |=> firstTimebase == $past(firstTimebase) + 16'h0001)
      else $error("first timebase step");
   chk_tb2_step: assert property (@(posedge clk) disable iff (sys_rst) // [RULE_14]
      tb2Tick |=> secondTimebase == $past(secondTimebase) + 16'h0001)
      else $error("second timebase step");
   chk_gate_low: assert property (@(posedge clk) disable iff (sys_rst) // [RULE_06]
      cgSel && !pinFilt |=> $stable(secondTimebase))
      else $error("gate did not block");
   chk_gate_step: assert property (@(posedge clk) disable iff (sys_rst) // [RULE_06]
      cgSel && pinFilt && div8Tick && p2Sel == 2'h0 |=>
      secondTimebase == $past(secondTimebase) + 16'h0001)
      else $error("open gate did not count");
   chk_pin_step: assert property (@(posedge clk) disable iff (sys_rst) // [RULE_05]
      !cgSel && !stopped && pinFilt && !pinFiltDly && p2Sel == 2'h0 |=>
      secondTimebase == $past(secondTimebase) + 16'h0001)
      else $error("pin edge did not count");

   // Output checks
   chk_level_nmi: assert property (@(posedge clk) disable iff (sys_rst) // [RULE_12]
      lvl == 3'h7 |=> nonmaskableReq)
      else $error("level seven not nonmaskable");
   chk_level_off: assert property (@(posedge clk) disable iff (sys_rst) // [RULE_12]
      lvl == 3'h0 |=> !channelIrqEnable)
      else $error("level zero did not disable");
   chk_vector_form: assert property (@(posedge clk) disable iff (sys_rst) // [RULE_13]
      !$past(sys_rst) |-> interruptVector == {$past(bv), $past(reqChannel)})
      else $error("vector wrong");
endmodule

// *** tbp_host.sv ***
/*
 Host model: an APB master that runs one transfer per call.
 Assumes the slave samples on the rising edge of clk.
*/
`timescale 1ns/1ps
module tbp_host (
   input wire logic clk,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [11:0] paddr,
   output logic [31:0] pwdata
);
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
   end
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
         output logic [31:0] r, output logic e, output logic to);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      to = 1'b1;
      while (to && n < 50) begin
         @(posedge clk);
         n++;
         if (pready === 1'b1) begin
            r = prdata;
            e = pslverr;
            to = 1'b0;
         end
      end
      psel <= 1'b0;
      penable <= 1'b0;
      // Released lines no longer show the last value
      paddr <= ~a;
      pwdata <= ~d;
   endtask
endmodule

// *** tbp_timebase_bench.sv ***
/*
 Self-checking bench for the timebase block with a host model.
 Assumes a 25 MHz clock and the register map of the package.
*/
`timescale 1ns/1ps
module tbp_timebase_bench;
   import tbp_pkg::*;
   logic clk, sysRst, timebasePin, supervisorFunctionLine;
   logic psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0] reqChannel, arb;
   logic [15:0] firstTimebase, secondTimebase;
   logic emulationFetchPath, hostRamBlock, registersRestricted;
   logic nonmaskableReq, channelIrqEnable, stopped;
   logic [2:0] requestLevel;
   logic [3:0] arbitrationNumber;
   logic [7:0] interruptVector;
   logic [31:0] expQ[$], resQ[$];
   int n_errors = 0, n_tests = 0;
   tbp_host host (.clk(clk), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
   tbp_timebase DUT (.clk(clk), .sys_rst(sysRst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .timebasePin(timebasePin),
      .supervisorFunctionLine(supervisorFunctionLine), .reqChannel(reqChannel),
      .firstTimebase(firstTimebase), .secondTimebase(secondTimebase),
      .emulationFetchPath(emulationFetchPath), .hostRamBlock(hostRamBlock),
      .registersRestricted(registersRestricted), .requestLevel(requestLevel),
      .nonmaskableReq(nonmaskableReq), .channelIrqEnable(channelIrqEnable),
      .arbitrationNumber(arbitrationNumber), .interruptVector(interruptVector),
      .stopped(stopped));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task automatic close_out;
      $display("comparisons %0d, mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic fail;
      n_errors++;
      close_out();
   endtask
   task automatic cmp_word(input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         n_errors++;
         $display("wrong value at %0t: got %h, expected %h", $time, g, e);
      end
   endtask
   task automatic chk(input logic [31:0] e, input logic [31:0] g);
      expQ.push_back(e);
      resQ.push_back(g);
   endtask
   // Monitor takes the oldest note for each result seen
   always @(negedge clk) begin
      while (resQ.size() > 0) cmp_word(expQ.pop_front(), resQ.pop_front());
   end
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic acc(input logic w, input logic [11:0] a, input logic [15:0] d,
         output logic [31:0] r, output logic e);
      logic to;
      host.xfer(w, a, {16'h0000, d}, r, e, to);
      if (to) fail();
   endtask
   function automatic logic [15:0] mc(input int st, p1, p2, em, cg, sv, ps);
      return 16'((st << STOP_BIT) | (p1 << P1_LSB) | (p2 << P2_LSB) | (em << EMU_BIT)
         | (cg << CG_BIT) | (sv << SUPERVISOR_SPACE_BIT) | (ps << PRESCALER_CLOCK_SELECT_BIT)) | {12'h000, arb};
   endfunction
   function automatic logic [15:0] tbv(input bit two);
      return two ? secondTimebase : firstTimebase;
   endfunction
   // Second of two intervals between counter steps, in clocks
   task automatic gap(input bit two, output int c);
      logic [15:0] v;
      for (int k = 0; k < 2; k++) begin
         v = tbv(two);
         c = 0;
         while (tbv(two) === v) begin
            @(negedge clk);
            c++;
            if (c > 600) fail();
         end
      end
   endtask
   initial begin
      logic [31:0] r;
      logic e;
      logic [15:0] v;
      int c;
      logic [3:0] b;
      sysRst = 1'b1;
      timebasePin = 1'b0;
      supervisorFunctionLine = 1'b0;
      reqChannel = 4'h0;
      void'($urandom(32'h5ea67f43));
      arb = 4'($urandom_range(15, 1));
      cyc(4);
      sysRst <= 1'b0;
      acc(1'b0, ADDR_MODCFG, 16'h0, r, e);
      chk({16'h0000, MODCFG_RESET}, r);
      acc(1'b0, 12'h004, 16'h0, r, e);
      chk(32'h1, {r[30:0], e});
      acc(1'b1, ADDR_MODCFG, mc(0, 0, 0, 1, 0, 0, 0), r, e);
      cyc(2);
      chk(32'h3, 32'({emulationFetchPath, hostRamBlock}));
      chk(32'(arb), 32'(arbitrationNumber));
      acc(1'b1, ADDR_MODCFG, mc(0, 0, 0, 0, 0, 0, 0), r, e);
      acc(1'b0, ADDR_MODCFG, 16'h0, r, e);
      chk(32'(mc(0, 0, 0, 1, 0, 0, 0)), r);
      sysRst <= 1'b1;
      cyc(2);
      sysRst <= 1'b0;
      cyc(2);
      chk(32'h0, 32'({emulationFetchPath, hostRamBlock}));
      $display("test emulation done");
      for (int k = 0; k < 8; k++) begin
         acc(1'b1, ADDR_MODCFG, mc(0, k % 4, 0, 0, 0, 0, k < 4), r, e);
         gap(1'b0, c);
         chk(32'((k < 4 ? 4 : 32) << (k % 4)), 32'(c));
      end
      $display("test first timebase done");
      cyc(1);
      timebasePin <= 1'b1;
      for (int k = 0; k < 4; k++) begin
         acc(1'b1, ADDR_MODCFG, mc(0, 0, k, 0, 1, 0, 1), r, e);
         gap(1'b1, c);
         chk(32'(8 << k), 32'(c));
      end
      cyc(1);
      timebasePin <= 1'b0;
      cyc(20);
      v = secondTimebase;
      cyc(100);
      chk(32'(v), 32'(secondTimebase));
      acc(1'b1, ADDR_MODCFG, mc(0, 0, 1, 0, 0, 0, 1), r, e);
      cyc(20);
      v = secondTimebase;
      repeat (16) begin
         timebasePin <= 1'b1;
         cyc(10);
         timebasePin <= 1'b0;
         cyc(10);
      end
      chk(32'(v + 16'h0008), 32'(secondTimebase));
      acc(1'b0, ADDR_TB2, 16'h0, r, e);
      chk(32'(v + 16'h0008), r);
      $display("test second timebase done");
      acc(1'b1, ADDR_MODCFG, mc(1, 0, 0, 0, 0, 0, 1), r, e);
      cyc(3);
      v = firstTimebase;
      cyc(50);
      chk(32'({v, 1'b1}), 32'({firstTimebase, stopped}));
      acc(1'b0, ADDR_TB1, 16'h0, r, e);
      chk({16'h0000, v}, r);
      acc(1'b0, ADDR_MODCFG, 16'h0, r, e);
      chk(32'(mc(1, 0, 0, 0, 0, 0, 1)) | 32'h100, r);
      acc(1'b1, ADDR_MODCFG, mc(0, 0, 0, 0, 0, 0, 1), r, e);
      cyc(3);
      chk(32'h0, 32'(stopped));
      $display("test stop done");
      for (int k = 0; k < 4; k++) begin
         supervisorFunctionLine <= k[0];
         acc(1'b1, ADDR_MODCFG, mc(0, 0, 0, 0, 0, k / 2, 1), r, e);
         cyc(2);
         chk(32'(k == 3), 32'(registersRestricted));
      end
      $display("test supervisor done");
      for (int k = 0; k < 8; k++) begin
         b = 4'($urandom);
         reqChannel <= 4'($urandom);
         acc(1'b1, ADDR_INTCFG, 16'((k << LVL_LSB) | (b << BV_LSB)), r, e);
         cyc(2);
         chk(32'({3'(k), k == 7, k != 0, b, reqChannel}), 32'({requestLevel, nonmaskableReq,
            channelIrqEnable, interruptVector}));
         acc(1'b0, ADDR_INTCFG, 16'h0, r, e);
         chk(32'((k << LVL_LSB) | (b << BV_LSB)), r);
         acc(1'b0, ADDR_VECQ, 16'h0, r, e);
         chk({23'h0, b, reqChannel, 1'b0}, {r[30:0], e});
      end
      $display("test interrupt config done");
      cyc(2);
      close_out();
   end
endmodule
